// ### src/bsf_pkg.sv
// constants and pin bundles for the bidirectional fifo port controller
package bsf_pkg;
    localparam int DATA_W = 18;
    localparam int FIFO_DEPTH = 32;
    localparam int CNT_W = 6;
    localparam int OFS_W = 9;
    localparam int FLAG_W = 10;
    localparam logic [FLAG_W-1:0] DEPTH_CMP = 10'h020;
    localparam logic [OFS_W-1:0] OFS_RESET = 9'h008;
    localparam logic [2:0] ADDR_FIFO = 3'h0;
    localparam logic [2:0] ADDR_BYPASS = 3'h1;
    localparam logic [2:0] ADDR_AB_AE = 3'h4;
    localparam logic [2:0] ADDR_AB_AF = 3'h5;
    localparam logic [2:0] ADDR_BA_AE = 3'h6;
    localparam logic [2:0] ADDR_BA_AF = 3'h7;

    typedef struct packed {
        logic clk;
        logic cs_n;
        logic [2:0] addr;
        logic rw;
        logic en_n;
        logic oe_n;
        logic [DATA_W-1:0] data;
    } bsf_pa_t;

    typedef struct packed {
        logic clk;
        logic rw;
        logic en_n;
        logic oe_n;
        logic [DATA_W-1:0] data;
    } bsf_pb_t;
endpackage

// ### src/bsf_bidir_fifo.sv
// one-direction word fifo and the two-port controller with bypass and flags
// Operation
// - two 18-bit bypass paths, one per direction
// - bypass indicator falls on b edge when addr 001
// - indicator rises on b edge when leaving bypass
// - each bypass path holds one word until read or bypass exit
// - a bypass write drops ab full, blocks writes
// - ab empty rises on next b edge
// - b bypass read loads output, flags release
// - b output enable still gates port b bus
// - b to a bypass works the same way
// - after leaving bypass fifo reads resume on b
// - select and address pick port a resource
// - port a write captures bus into input register
// - port a drives output register when reading
// - eight flags, four thresholds programmable
// - every offset resets to eight
// - each flag updates on its own port clock
// - flag update may slip one port edge
// - port b works regardless of port a select, except bypass writes
// - offset held in bits 8..0, rest ignored
// - flag thresholds follow count, depth and offsets
// - offset read returns value, no pointer moves
`timescale 1ns/1ps
module bsf_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // fill level
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
    } bsf_fifo_state_t;
    bsf_fifo_state_t r;
    bsf_fifo_state_t n;
    logic push;
    logic pop;
    assign in_ready = r.count != (AW+1)'(DEPTH);
    assign out_valid = r.count != '0;
    assign out_data = r.mem[r.rd_ptr];
    assign level = r.count;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always_comb begin
        n = r;
        if (push) begin
            n.mem[r.wr_ptr] = in_data;
            n.wr_ptr = r.wr_ptr + 1'b1;
        end
        if (pop) begin
            n.rd_ptr = r.rd_ptr + 1'b1;
        end
        n.count = r.count + (AW+1)'(push) - (AW+1)'(pop);
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
endmodule
module bsf_bidir_fifo (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // port a pins
    input wire logic port_a_clock,
    input wire logic port_a_select_n,
    input wire logic [2:0] port_a_resource_select,
    input wire logic port_a_read_write,
    input wire logic port_a_enable_n,
    input wire logic port_a_output_enable_n,
    input wire logic [bsf_pkg::DATA_W-1:0] port_a_data_in,
    output logic [bsf_pkg::DATA_W-1:0] port_a_data_out,
    output logic port_a_data_oe_n,
    // port b pins
    input wire logic port_b_clock,
    input wire logic port_b_read_write,
    input wire logic port_b_enable_n,
    input wire logic port_b_output_enable_n,
    input wire logic [bsf_pkg::DATA_W-1:0] port_b_data_in,
    output logic [bsf_pkg::DATA_W-1:0] port_b_data_out,
    output logic port_b_data_oe_n,
    // a to b flags
    output logic ab_empty_n,
    output logic ab_almost_empty_n,
    output logic ab_almost_full_n,
    output logic ab_full_n,
    // b to a flags
    output logic ba_empty_n,
    output logic ba_almost_empty_n,
    output logic ba_almost_full_n,
    output logic ba_full_n,
    // bypass
    output logic bypass_indicator_n
);
    import bsf_pkg::*;
    typedef struct packed {
        bsf_pa_t pa_meta;
        bsf_pa_t pa_sync;
        logic pa_clk_d;
        bsf_pb_t pb_meta;
        bsf_pb_t pb_sync;
        logic pb_clk_d;
        logic a_upd;
        logic b_upd;
        logic [DATA_W-1:0] a_in;
        logic [DATA_W-1:0] a_out;
        logic [DATA_W-1:0] b_in;
        logic [DATA_W-1:0] b_out;
        logic ab_pend;
        logic ba_pend;
        logic byp_n;
        logic [OFS_W-1:0] ab_ae_ofs;
        logic [OFS_W-1:0] ab_af_ofs;
        logic [OFS_W-1:0] ba_ae_ofs;
        logic [OFS_W-1:0] ba_af_ofs;
        logic ab_empty_n;
        logic ab_ae_n;
        logic ab_af_n;
        logic ab_full_n;
        logic ba_empty_n;
        logic ba_ae_n;
        logic ba_af_n;
        logic ba_full_n;
    } bsf_state_t;
    bsf_state_t r;
    bsf_state_t n;
    bsf_pa_t pa_pins;
    bsf_pb_t pb_pins;
    logic a_edge;
    logic b_edge;
    logic a_sel;
    logic a_byp;
    logic a_wr;
    logic a_rd;
    logic b_wr;
    logic b_rd;
    logic ab_push;
    logic ab_ready;
    logic ab_valid;
    logic ab_pop;
    logic [DATA_W-1:0] ab_data;
    logic [CNT_W-1:0] ab_lvl;
    logic ba_push;
    logic ba_ready;
    logic ba_valid;
    logic ba_pop;
    logic [DATA_W-1:0] ba_data;
    logic [CNT_W-1:0] ba_lvl;
    logic [FLAG_W-1:0] ab_l10;
    logic [FLAG_W-1:0] ba_l10;
    assign pa_pins = {port_a_clock, port_a_select_n, port_a_resource_select,
                      port_a_read_write, port_a_enable_n,
                      port_a_output_enable_n, port_a_data_in};
    assign pb_pins = {port_b_clock, port_b_read_write, port_b_enable_n,
                      port_b_output_enable_n, port_b_data_in};
    // port clock edges found on the synchronised copies
    assign a_edge = r.pa_sync.clk && !r.pa_clk_d;
    assign b_edge = r.pb_sync.clk && !r.pb_clk_d;
    assign a_sel = !r.pa_sync.cs_n;
    assign a_byp = a_sel && r.pa_sync.addr == ADDR_BYPASS;
    assign a_wr = !r.pa_sync.rw && !r.pa_sync.en_n;
    assign a_rd = r.pa_sync.rw && !r.pa_sync.en_n;
    assign b_wr = !r.pb_sync.rw && !r.pb_sync.en_n;
    assign b_rd = r.pb_sync.rw && !r.pb_sync.en_n;
    assign ab_l10 = {{(FLAG_W-CNT_W){1'b0}}, ab_lvl};
    assign ba_l10 = {{(FLAG_W-CNT_W){1'b0}}, ba_lvl};

    bsf_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_ab_fifo (
        .core_clk(core_clk),
        .rst(rst),
        .in_valid(ab_push),
        .in_ready(ab_ready),
        .in_data(r.pa_sync.data),
        .out_valid(ab_valid),
        .out_ready(ab_pop),
        .out_data(ab_data),
        .level(ab_lvl)
    );

    bsf_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_ba_fifo (
        .core_clk(core_clk),
        .rst(rst),
        .in_valid(ba_push),
        .in_ready(ba_ready),
        .in_data(r.pb_sync.data),
        .out_valid(ba_valid),
        .out_ready(ba_pop),
        .out_data(ba_data),
        .level(ba_lvl)
    );

    always_comb begin
        n = r;
        ab_push = 1'b0;
        ab_pop = 1'b0;
        ba_push = 1'b0;
        ba_pop = 1'b0;
        n.pa_meta = pa_pins;
        n.pa_sync = r.pa_meta;
        n.pa_clk_d = r.pa_sync.clk;
        n.pb_meta = pb_pins;
        n.pb_sync = r.pb_meta;
        n.pb_clk_d = r.pb_sync.clk;
        // flags are evaluated one cycle after the edge, once counts settle
        n.a_upd = a_edge;
        n.b_upd = b_edge;
        // bypass indicator follows port a on each b edge
        if (b_edge) begin
            n.byp_n = !a_byp;
            if (!r.byp_n && !a_byp) begin
                // leaving bypass frees both one-word paths
                n.ab_pend = 1'b0;
                n.ba_pend = 1'b0;
            end
        end
        // port a, only while selected
        if (a_edge && a_sel) begin
            if (a_wr) begin
                unique case (r.pa_sync.addr)
                    ADDR_FIFO: begin
                        ab_push = 1'b1;
                        if (!r.ab_pend) begin
                            n.a_in = r.pa_sync.data;
                        end
                    end
                    ADDR_BYPASS: begin
                        // blocked while the previous word is unread
                        if (!r.ab_pend) begin
                            n.a_in = r.pa_sync.data;
                            n.ab_pend = 1'b1;
                        end
                    end
                    ADDR_AB_AE: n.ab_ae_ofs = r.pa_sync.data[OFS_W-1:0];
                    ADDR_AB_AF: n.ab_af_ofs = r.pa_sync.data[OFS_W-1:0];
                    ADDR_BA_AE: n.ba_ae_ofs = r.pa_sync.data[OFS_W-1:0];
                    ADDR_BA_AF: n.ba_af_ofs = r.pa_sync.data[OFS_W-1:0];
                    default: ;
                endcase
            end else if (a_rd) begin
                unique case (r.pa_sync.addr)
                    ADDR_FIFO: begin
                        if (ba_valid) begin
                            n.a_out = ba_data;
                            ba_pop = 1'b1;
                        end
                    end
                    ADDR_BYPASS: begin
                        if (r.ba_pend) begin
                            n.a_out = r.b_in;
                            n.ba_pend = 1'b0;
                        end
                    end
                    ADDR_AB_AE: n.a_out = DATA_W'(r.ab_ae_ofs);
                    ADDR_AB_AF: n.a_out = DATA_W'(r.ab_af_ofs);
                    ADDR_BA_AE: n.a_out = DATA_W'(r.ba_ae_ofs);
                    ADDR_BA_AF: n.a_out = DATA_W'(r.ba_af_ofs);
                    default: ;
                endcase
            end
        end
        // port b, independent of the port a select except for bypass writes, which need a_byp
        if (b_edge) begin
            if (b_wr) begin
                if (!r.byp_n) begin
                    if (!r.ba_pend && a_byp) begin
                        n.b_in = r.pb_sync.data;
                        n.ba_pend = 1'b1;
                    end
                end else begin
                    ba_push = 1'b1;
                    if (!r.ba_pend) begin
                        n.b_in = r.pb_sync.data;
                    end
                end
            end else if (b_rd) begin
                // old indicator still low: last bypass read allowed
                if (!r.byp_n) begin
                    if (r.ab_pend) begin
                        n.b_out = r.a_in;
                        n.ab_pend = 1'b0;
                    end
                end else if (ab_valid) begin
                    n.b_out = ab_data;
                    ab_pop = 1'b1;
                end
            end
        end
        // flags seen by port a
        if (r.a_upd) begin
            n.ab_full_n = a_byp ? !r.ab_pend
                                : ab_l10 != DEPTH_CMP;
            n.ab_af_n = !(ab_l10 + FLAG_W'(r.ab_af_ofs) >= DEPTH_CMP);
            n.ba_empty_n = a_byp ? r.ba_pend
                                 : ba_l10 != '0;
            n.ba_ae_n = !(ba_l10 <= FLAG_W'(r.ba_ae_ofs));
        end
        // flags seen by port b
        if (r.b_upd) begin
            n.ab_empty_n = !r.byp_n ? r.ab_pend
                                    : ab_l10 != '0;
            n.ab_ae_n = !(ab_l10 <= FLAG_W'(r.ab_ae_ofs));
            n.ba_full_n = !r.byp_n ? !r.ba_pend
                                   : ba_l10 != DEPTH_CMP;
            n.ba_af_n = !(ba_l10 + FLAG_W'(r.ba_af_ofs) >= DEPTH_CMP);
        end
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            r <= '0;
            r.byp_n <= 1'b1;
            r.ab_ae_ofs <= OFS_RESET;
            r.ab_af_ofs <= OFS_RESET;
            r.ba_ae_ofs <= OFS_RESET;
            r.ba_af_ofs <= OFS_RESET;
            r.ab_af_n <= 1'b1;
            r.ab_full_n <= 1'b1;
            r.ba_af_n <= 1'b1;
            r.ba_full_n <= 1'b1;
        end else begin
            r <= n;
        end
    end
    // three-state controls, low enable means driving
    assign port_a_data_oe_n = !(a_sel && r.pa_sync.rw
                                && !r.pa_sync.oe_n);
    assign port_a_data_out = r.a_out;
    assign port_b_data_oe_n = !(r.pb_sync.rw && !r.pb_sync.oe_n);
    assign port_b_data_out = r.b_out;
    assign ab_empty_n = r.ab_empty_n;
    assign ab_almost_empty_n = r.ab_ae_n;
    assign ab_almost_full_n = r.ab_af_n;
    assign ab_full_n = r.ab_full_n;
    assign ba_empty_n = r.ba_empty_n;
    assign ba_almost_empty_n = r.ba_ae_n;
    assign ba_almost_full_n = r.ba_af_n;
    assign ba_full_n = r.ba_full_n;
    assign bypass_indicator_n = r.byp_n;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    byp_enter_a: assert property (
        b_edge && a_byp |=> !bypass_indicator_n)
        else $error("bypass indicator did not fall");
    byp_leave_a: assert property (
        b_edge && !a_byp |=> bypass_indicator_n)
        else $error("bypass indicator did not rise");
    byp_full_a: assert property (
        a_edge && a_byp && a_wr && !r.ab_pend |-> ##2 !ab_full_n)
        else $error("ab full not low after bypass write");
    byp_empty_a: assert property (
        b_edge && !r.byp_n && r.ab_pend && !b_rd && a_byp
        |-> ##2 ab_empty_n)
        else $error("ab empty not high with bypass word");
    byp_read_a: assert property (
        b_edge && !r.byp_n && b_rd && r.ab_pend
        |=> r.b_out == $past(r.a_in) && !r.ab_pend)
        else $error("bypass word not moved to port b");
    ofs_write_a: assert property (
        a_edge && a_sel && a_wr && r.pa_sync.addr == ADDR_AB_AE
        |=> r.ab_ae_ofs == $past(r.pa_sync.data[OFS_W-1:0]))
        else $error("offset register not written");
    ofs_read_a: assert property (
        a_edge && a_sel && a_rd && r.pa_sync.addr[2]
        |-> !ba_pop ##1 r.a_out[DATA_W-1:OFS_W] == '0)
        else $error("offset read wrong upper bits");
    a_capture_a: assert property (
        a_edge && a_sel && a_wr && r.pa_sync.addr == ADDR_FIFO
        && !r.ab_pend |=> r.a_in == $past(r.pa_sync.data))
        else $error("port a input register not loaded");
    full_flag_a: assert property (
        r.a_upd && !a_byp |=> ab_full_n == ($past(ab_l10) != DEPTH_CMP))
        else $error("ab full flag wrong");
endmodule

// ### verif/bsf_port_b_model.sv
// port b processor model driving the port b pins of the fifo
`timescale 1ns/1ps
module bsf_port_b_model (
    // core clock used to place pin changes
    input wire logic core_clk,
    // port b pins
    output logic port_b_clock,
    output logic port_b_read_write,
    output logic port_b_enable_n,
    output logic port_b_output_enable_n,
    output logic [bsf_pkg::DATA_W-1:0] port_b_data_in,
    input wire logic [bsf_pkg::DATA_W-1:0] port_b_data_out,
    input wire logic port_b_data_oe_n
);
    import bsf_pkg::*;
    logic [DATA_W-1:0] drv;
    // wire level of the shared bus
    assign port_b_data_in = port_b_data_oe_n ? drv : port_b_data_out;
    initial begin
        port_b_clock = 1'b0;
        port_b_read_write = 1'b1;
        port_b_enable_n = 1'b1;
        port_b_output_enable_n = 1'b1;
        drv = 18'h00000;
    end
    // one frame; controls hold across the clock pulse, clock idles low
    task automatic b_cycle(input logic rw, input logic en_n,
                           input logic oe_n, input logic [DATA_W-1:0] d);
        @(negedge core_clk);
        port_b_read_write = rw;
        port_b_enable_n = en_n;
        port_b_output_enable_n = oe_n;
        // a released bus must not keep showing the last word
        drv = rw ? ~drv : d;
        #24 port_b_clock = 1'b1;
        #24 port_b_clock = 1'b0;
        repeat (6) @(negedge core_clk);
    endtask
endmodule

// ### verif/tb.sv
// self-checking testbench for the bidirectional fifo port controller
`timescale 1ns/1ps
module tb;
    import bsf_pkg::*;
    logic core_clk;
    logic rst;
    logic a_clk, a_cs_n, a_rw, a_en_n, a_oe_n;
    logic [2:0] a_addr;
    logic [DATA_W-1:0] a_drv, a_din, a_dout, b_din, b_dout;
    logic a_doe_n, b_clk, b_rw, b_en_n, b_oe_n, b_doe_n;
    logic ab_e, ab_ae, ab_af, ab_f, ba_e, ba_ae, ba_af, ba_f, byp_n;
    int n_fail;
    int num_checks;

    assign a_din = a_doe_n ? a_drv : a_dout;

    bsf_bidir_fifo i_bsf_bidir_fifo (
        .core_clk(core_clk), .rst(rst),
        .port_a_clock(a_clk), .port_a_select_n(a_cs_n),
        .port_a_resource_select(a_addr), .port_a_read_write(a_rw),
        .port_a_enable_n(a_en_n), .port_a_output_enable_n(a_oe_n),
        .port_a_data_in(a_din), .port_a_data_out(a_dout),
        .port_a_data_oe_n(a_doe_n),
        .port_b_clock(b_clk), .port_b_read_write(b_rw),
        .port_b_enable_n(b_en_n), .port_b_output_enable_n(b_oe_n),
        .port_b_data_in(b_din), .port_b_data_out(b_dout),
        .port_b_data_oe_n(b_doe_n),
        .ab_empty_n(ab_e), .ab_almost_empty_n(ab_ae),
        .ab_almost_full_n(ab_af), .ab_full_n(ab_f),
        .ba_empty_n(ba_e), .ba_almost_empty_n(ba_ae),
        .ba_almost_full_n(ba_af), .ba_full_n(ba_f),
        .bypass_indicator_n(byp_n)
    );

    bsf_port_b_model i_bsf_port_b_model (
        .core_clk(core_clk), .port_b_clock(b_clk),
        .port_b_read_write(b_rw), .port_b_enable_n(b_en_n),
        .port_b_output_enable_n(b_oe_n), .port_b_data_in(b_din),
        .port_b_data_out(b_dout), .port_b_data_oe_n(b_doe_n)
    );

    always #2.5 core_clk = ~core_clk;

    task automatic chk(input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic chkb(input logic seen, input logic exp);
        chk({17'h00000, seen}, {17'h00000, exp});
    endtask

    task automatic tally_and_finish;
        if (n_fail == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // one port a frame; output enable follows the read direction
    task automatic a_cycle(input logic [2:0] ad, input logic rw,
                           input logic en_n, input logic [DATA_W-1:0] d);
        @(negedge core_clk);
        a_addr = ad;
        a_rw = rw;
        a_en_n = en_n;
        a_oe_n = !rw;
        a_drv = rw ? ~a_drv : d;
        #24 a_clk = 1'b1;
        #24 a_clk = 1'b0;
        repeat (6) @(negedge core_clk);
    endtask

    task automatic b_idle;
        i_bsf_port_b_model.b_cycle(1'b1, 1'b1, 1'b1, 18'h00000);
    endtask

    initial begin
        #200000;
        n_fail++;
        tally_and_finish();
    end

    initial begin
        core_clk = 1'b0;
        rst = 1'b1;
        n_fail = 0;
        num_checks = 0;
        a_clk = 1'b0;
        a_cs_n = 1'b1;
        a_rw = 1'b1;
        a_en_n = 1'b1;
        a_oe_n = 1'b1;
        a_addr = 3'h0;
        a_drv = 18'h00000;
        repeat (8) @(negedge core_clk);
        rst = 1'b0;
        repeat (4) @(negedge core_clk);
        chk({9'h000, ab_e, ab_ae, ab_af, ab_f, ba_e, ba_ae, ba_af, ba_f,
             byp_n}, 18'h00067);
        chk(a_dout, 18'h00000);
        chkb(b_doe_n, 1'b1);
        a_cs_n = 1'b0;
        for (int i = 0; i < 4; i++) begin
            a_cycle(ADDR_AB_AE + 3'(i), 1'b1, 1'b0, 18'h00000);
            chk(a_dout, {9'h000, OFS_RESET});
            a_cycle(ADDR_AB_AE + 3'(i), 1'b0, 1'b0,
                    18'h3FE03 + 18'(i));
            a_cycle(ADDR_AB_AE + 3'(i), 1'b1, 1'b0, 18'h00000);
            chk(a_dout, 18'h00003 + 18'(i));
        end
        a_cycle(3'h2, 1'b0, 1'b0, 18'h00ABC);
        b_idle();
        chkb(ab_e, 1'b0);
        // fill until refused; far side stalls
        for (int i = 0; i < 33; i++) begin
            a_cycle(ADDR_FIFO, 1'b0, 1'b0, 18'h10000 + 18'(i));
            chkb(a_doe_n, 1'b1);
            chkb(ab_f, i < 31);
            chkb(ab_af, i < 27);
        end
        b_idle();
        chkb(ab_e, 1'b1);
        chkb(ab_ae, 1'b1);
        a_cs_n = 1'b1;
        for (int k = 0; k < 32; k++) begin
            i_bsf_port_b_model.b_cycle(1'b1, 1'b0, 1'b0, 18'h00000);
            chk(b_dout, 18'h10000 + 18'(k));
            chkb(b_doe_n, 1'b0);
            chkb(ab_e, k != 31);
            chkb(ab_ae, 31 - k > 3);
        end
        a_cs_n = 1'b0;
        a_cycle(ADDR_FIFO, 1'b1, 1'b1, 18'h00000);
        chkb(ab_f, 1'b1);
        i_bsf_port_b_model.b_cycle(1'b0, 1'b0, 1'b1, 18'h2AAAA);
        i_bsf_port_b_model.b_cycle(1'b0, 1'b0, 1'b1, 18'h15555);
        a_cycle(ADDR_FIFO, 1'b1, 1'b1, 18'h00000);
        chkb(ba_e, 1'b1);
        chkb(ba_ae, 1'b0);
        a_cycle(ADDR_FIFO, 1'b1, 1'b0, 18'h00000);
        chk(a_dout, 18'h2AAAA);
        chkb(a_doe_n, 1'b0);
        a_cycle(ADDR_FIFO, 1'b1, 1'b0, 18'h00000);
        chk(a_dout, 18'h15555);
        chkb(ba_e, 1'b0);
        // a to b bypass, second write must be blocked
        a_cycle(ADDR_BYPASS, 1'b1, 1'b1, 18'h00000);
        b_idle();
        chkb(byp_n, 1'b0);
        a_cycle(ADDR_BYPASS, 1'b0, 1'b0, 18'h0BEEF);
        chkb(ab_f, 1'b0);
        a_cycle(ADDR_BYPASS, 1'b0, 1'b0, 18'h0DEAD);
        b_idle();
        chkb(ab_e, 1'b1);
        i_bsf_port_b_model.b_cycle(1'b1, 1'b0, 1'b1, 18'h00000);
        chk(b_dout, 18'h0BEEF);
        chkb(b_doe_n, 1'b1);
        chkb(ab_e, 1'b0);
        a_cycle(ADDR_BYPASS, 1'b1, 1'b1, 18'h00000);
        chkb(ab_f, 1'b1);
        // b to a bypass
        i_bsf_port_b_model.b_cycle(1'b0, 1'b0, 1'b1, 18'h0CAFE);
        chkb(ba_f, 1'b0);
        a_cycle(ADDR_BYPASS, 1'b1, 1'b1, 18'h00000);
        chkb(ba_e, 1'b1);
        a_cycle(ADDR_BYPASS, 1'b1, 1'b0, 18'h00000);
        chk(a_dout, 18'h0CAFE);
        chkb(ba_e, 1'b0);
        b_idle();
        chkb(ba_f, 1'b1);
        a_cycle(ADDR_FIFO, 1'b0, 1'b0, 18'h00777);
        b_idle();
        chkb(byp_n, 1'b1);
        i_bsf_port_b_model.b_cycle(1'b1, 1'b0, 1'b0, 18'h00000);
        chk(b_dout, 18'h00777);
        a_cycle(ADDR_BYPASS, 1'b1, 1'b1, 18'h00000);
        b_idle();
        chkb(byp_n, 1'b0);
        a_cs_n = 1'b1;
        b_idle();
        chkb(byp_n, 1'b1);
        // b to a almost-full with offset 6, port a deselected
        for (int k = 0; k < 26; k++) begin
            i_bsf_port_b_model.b_cycle(1'b0, 1'b0, 1'b1, 18'h20000 + 18'(k));
            chkb(ba_af, k < 25);
        end
        tally_and_finish();
    end
endmodule
